// ==== rtl/scsm_coef_rom.sv ====
// Coefficient default ROM with one cycle of read latency.
`timescale 1ns/100ps
`include "scsm_consts.svh"
module scsm_coef_rom
  import scsm_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  scsm_rom_if.rom   rom_bus
);

  // Location 00 sits in the lowest byte.
  localparam logic [79:0][7:0] TABLE = {
    128'h00005417797f7f0200006d17797f7f04,
    128'h00570d86777f44803b7f206e7f006680,
    128'h00001b4e4482667f3a81467f30184482,
    128'h5e7f44813b7ff100778077803020324e,
    128'h7f82587f1c81467f3014106a7f2381e0
  };

  scsm_rom_state_t state_reg;
  scsm_rom_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.data = (rom_bus.addr <= `SCSM_COEF_LAST) ?
                      TABLE[rom_bus.addr] : 8'h00;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rom_bus.data = state_reg.data;

endmodule : scsm_coef_rom

// ==== rtl/scsm_coef_rom_fix_note_unused.sv ====
// Spare source file; it holds no logic.
`timescale 1ns/100ps

// ==== rtl/scsm_consts.svh ====
// Constants of the servo command and status-sense multiplexer.
`ifndef SCSM_CONSTS_SVH
`define SCSM_CONSTS_SVH

// ****************************************************************
// APB register offsets
// ****************************************************************
`define SCSM_OFF_CMD        8'h00
`define SCSM_OFF_STATUS     8'h04
`define SCSM_OFF_COEF_IDX   8'h08
`define SCSM_OFF_COEF_DATA  8'h0c

// ****************************************************************
// Command address codes and sub-codes
// ****************************************************************
`define SCSM_A_FOCUS   4'h0
`define SCSM_A_TRACK   4'h1
`define SCSM_A_TMODE   4'h2
`define SCSM_A_SELECT  4'h3
`define SCSM_A_AUTO    4'h4
`define SCSM_A_BLIND   4'h5
`define SCSM_A_KICK    4'h6
`define SCSM_A_JUMP    4'h7
`define SCSM_A_FUNC    4'h9
`define SCSM_A_AUDIO   4'ha
`define SCSM_A_TRAV    4'hb
`define SCSM_A_SPIN    4'hc
`define SCSM_A_CLVM    4'he
`define SCSM_SUB_COEF  4'h4
`define SCSM_SUB_LEVEL 4'h8
`define SCSM_SUB_READ  4'h9
`define SCSM_RD_TE     8'h04
`define SCSM_RD_FE     8'h08
`define SCSM_RD_VC     8'h0c
`define SCSM_RD_TRVSC  8'h1c
`define SCSM_RD_FB     8'h1d
`define SCSM_RD_RFDC   8'h1f

// ****************************************************************
// Field positions
// ****************************************************************
`define SCSM_AUTO_SEQUENCE_ENABLE_BIT  17
`define SCSM_AGT_BIT   8
`define SCSM_AGF_BIT   9
`define SCSM_DCLV_BIT  14
`define SCSM_AS_RANGE  19:16
`define SCSM_AS_HI     19:17
`define SCSM_TR_RANGE  19:16
`define SCSM_SD_RANGE  19:16
`define SCSM_KF_RANGE  15:12
`define SCSM_JC_RANGE  19:4
`define SCSM_MDS_RANGE 17:16
`define SCSM_MDP_RANGE 19:18

// ****************************************************************
// Masks of bits that are not don't-care, and preset values
// ****************************************************************
`define SCSM_MASK_LOW8 20'hfff00
`define SCSM_MASK_LOW4 20'hffff0
`define SCSM_MASK_ALL  20'hfffff
`define SCSM_PRE_ZERO  20'h00000
`define SCSM_PRE_1     20'h10000
`define SCSM_PRE_5     20'h50000
`define SCSM_PRE_6     20'h70000
`define SCSM_PRE_7     20'h01000
`define SCSM_PRE_9     20'h90000
`define SCSM_PRE_A     20'h30000
`define SCSM_PRE_B     20'h01000
`define SCSM_PRE_C     20'h60000

// ****************************************************************
// Counts
// ****************************************************************
`define SCSM_COEF_N     8'h50
`define SCSM_COEF_LAST  7'h4f
`define SCSM_SINGLE_AS  3'h2
`define SCSM_TRK8_LAST  3'h7
`define SCSM_LEN9       4'h9
`define SCSM_LEN8       4'h8

`endif

// ==== rtl/scsm_pkg.sv ====
// Types of the servo command and status-sense multiplexer.
`include "scsm_consts.svh"
package scsm_pkg;

  typedef struct packed {
    logic [15:0][19:0] regs;
    logic [23:0]       last_cmd;
    logic [15:0]       trk_cnt;
    logic [2:0]        trk8;
    logic              comp;
    logic              toggle;
    logic              pulse_d;
    logic [8:0]        shift;
    logic [3:0]        left;
    logic              rclk_d;
    logic [79:0][7:0]  coef;
    logic              init_busy;
    logic [6:0]        init_idx;
    logic              init_wr;
    logic [6:0]        init_wr_idx;
    logic [6:0]        coef_sel;
    logic [7:0]        coef_rd;
    logic [31:0]       prdata;
    logic              pslverr;
    logic              sense;
    logic              sense_oe;
  } scsm_state_t;

  typedef struct packed {
    logic [7:0] data;
  } scsm_rom_state_t;

endpackage : scsm_pkg

// ==== rtl/scsm_rom_if.sv ====
// Interface between the multiplexer and its coefficient ROM.
`timescale 1ns/100ps
interface scsm_rom_if;
  logic [6:0] addr;
  logic [7:0] data;
  modport user (output addr, input data);
  modport rom  (input addr, output data);
endinterface : scsm_rom_if

// ==== rtl/scsm_top.sv ====
// Servo command register map, coefficient memory and sense multiplexer.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`include "scsm_consts.svh"
module scsm_top
  import scsm_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        auto_seq_running_in,
  input  wire logic        focus_ok_in,
  input  wire logic        frame_sync_good_in,
  input  wire logic        track_pulse_input_in,
  input  wire logic        run_length_ge64_in,
  input  wire logic        auto_gain_done_in,
  input  wire logic        averaging_active_in,
  input  wire logic        average_busy_n_in,
  input  wire logic        sled_stop_indication_in,
  input  wire logic        focus_zero_cross_in,
  input  wire logic        anti_shock_in,
  input  wire logic        track_zero_cross_in,
  input  wire logic [8:0]  readout_value_in,
  input  wire logic        sense_read_clk_in,
  input  wire logic [6:0]  coef_rd_addr_in,
  output logic [7:0]       coef_rd_data_out,
  output logic             coef_init_busy_out,
  output logic             status_sense_pin_out,
  output logic             status_sense_pin_oe_out,
  output logic             auto_sequence_enable_out,
  output logic [3:0]       auto_seq_command_out,
  output logic [3:0]       blind_brake_timer_field_out,
  output logic [3:0]       sled_kick_timer_field_out,
  output logic [3:0]       focus_kick_timer_field_out,
  output logic [15:0]      jump_count_out,
  output logic [15:0]      traverse_count_out,
  output logic [1:0]       speed_drive_gain_out,
  output logic [1:0]       phase_drive_gain_out,
  output logic             digital_velocity_gain_out
);

  localparam logic [15:0][19:0] PRESETS = {
    `SCSM_PRE_ZERO, `SCSM_PRE_ZERO, `SCSM_PRE_ZERO, `SCSM_PRE_C,
    `SCSM_PRE_B, `SCSM_PRE_A, `SCSM_PRE_9, `SCSM_PRE_ZERO,
    `SCSM_PRE_7, `SCSM_PRE_6, `SCSM_PRE_5, `SCSM_PRE_ZERO,
    `SCSM_PRE_ZERO, `SCSM_PRE_ZERO, `SCSM_PRE_1, `SCSM_PRE_ZERO
  };
  localparam int INIT_MIN = 0;
  localparam int INIT_MAX = 82;

  scsm_state_t state_reg;
  scsm_state_t state_next;
  scsm_rom_if  rom_bus();

  scsm_coef_rom u_rom (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .rom_bus  (rom_bus)
  );

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic [19:0] cmd_mask(input logic [3:0] code);
    case (code)
      `SCSM_A_JUMP, `SCSM_A_TRAV:             cmd_mask = `SCSM_MASK_LOW4;
      `SCSM_A_FOCUS, `SCSM_A_TRACK,
      `SCSM_A_TMODE, `SCSM_A_SELECT:          cmd_mask = `SCSM_MASK_ALL;
      default:                                cmd_mask = `SCSM_MASK_LOW8;
    endcase
  endfunction : cmd_mask

  function automatic logic is_readout(input logic [7:0] sub);
    is_readout = (sub == `SCSM_RD_TE) || (sub == `SCSM_RD_FE) ||
                 (sub == `SCSM_RD_VC) || (sub == `SCSM_RD_TRVSC) ||
                 (sub == `SCSM_RD_FB) || (sub == `SCSM_RD_RFDC);
  endfunction : is_readout

  function automatic logic drives_always(input logic [3:0] code);
    drives_always = (code == `SCSM_A_AUDIO) || (code == `SCSM_A_TRAV) ||
                    (code == `SCSM_A_SPIN) || (code == `SCSM_A_CLVM);
  endfunction : drives_always

  // ****************************************************************
  // Bus and event decode
  // ****************************************************************
  logic        apb_setup;
  logic        cmd_wr;
  logic [3:0]  code;
  logic [19:0] data;
  logic [3:0]  last_code;
  logic [3:0]  last_sub;
  logic        auto_sequence_enable;
  logic        agc_cmd;
  logic        trk_rise;
  logic        rclk_rise;
  logic        single_jump;
  logic [15:0] trav_count;
  logic        trav_hit;
  logic        coef_busy;
  logic        readout_load;

  assign apb_setup   = psel_in && !penable_in;
  assign cmd_wr      = psel_in && penable_in && pwrite_in &&
                       (paddr_in == `SCSM_OFF_CMD);
  assign code        = pwdata_in[23:20];
  assign data        = pwdata_in[19:0];
  assign last_code   = state_reg.last_cmd[23:20];
  assign last_sub    = state_reg.last_cmd[19:16];
  assign auto_sequence_enable        = state_reg.regs[`SCSM_A_FUNC][`SCSM_AUTO_SEQUENCE_ENABLE_BIT];
  assign agc_cmd     = state_reg.last_cmd[`SCSM_AGT_BIT] ||
                       state_reg.last_cmd[`SCSM_AGF_BIT];
  assign trk_rise    = track_pulse_input_in && !state_reg.pulse_d;
  assign rclk_rise   = sense_read_clk_in && !state_reg.rclk_d;
  // Only the fine-search codes 4 and 5 count in groups of eight.
  assign single_jump = auto_seq_running_in &&
    (state_reg.regs[`SCSM_A_AUTO][`SCSM_AS_HI] == `SCSM_SINGLE_AS);
  assign trav_count  = state_reg.regs[`SCSM_A_TRAV][`SCSM_JC_RANGE];
  assign trav_hit    = (trav_count != 16'h0000) &&
                       (16'(state_reg.trk_cnt + 16'h0001) == trav_count);
  assign coef_busy   = state_reg.init_busy || state_reg.init_wr;
  assign readout_load = cmd_wr && (code == `SCSM_A_SELECT) &&
                        (pwdata_in[19:16] == `SCSM_SUB_READ) &&
                        is_readout(pwdata_in[15:8]);
  assign rom_bus.addr = state_reg.init_idx;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.pulse_d = track_pulse_input_in;
    state_next.rclk_d  = sense_read_clk_in;

    // Defaults stream from the ROM one location per cycle.
    state_next.init_wr     = state_reg.init_busy;
    state_next.init_wr_idx = state_reg.init_idx;
    if (state_reg.init_busy) begin
      if (state_reg.init_idx == `SCSM_COEF_LAST) begin
        state_next.init_busy = 1'b0;
      end else begin
        state_next.init_idx = 7'(state_reg.init_idx + 7'h01);
      end
    end
    if (state_reg.init_wr) begin
      state_next.coef[state_reg.init_wr_idx] = rom_bus.data;
    end

    if (cmd_wr) begin
      // Selection needs no latch pulse; the write itself selects.
      state_next.last_cmd = pwdata_in[23:0];
      // Fields of jump, traverse, timers and gains land here.
      state_next.regs[code] = (state_reg.regs[code] & ~cmd_mask(code)) |
                              (data & cmd_mask(code));
      if ((code == `SCSM_A_SELECT) &&
          (pwdata_in[19:16] == `SCSM_SUB_COEF) &&
          (pwdata_in[15:8] < `SCSM_COEF_N) && !coef_busy) begin
        state_next.coef[pwdata_in[14:8]] = pwdata_in[7:0];
      end
    end

    if (cmd_wr && (code == `SCSM_A_TRAV)) begin
      state_next.comp    = 1'b1;
      state_next.toggle  = 1'b1;
      state_next.trk_cnt = 16'h0000;
      state_next.trk8    = 3'h0;
    end else if (trk_rise) begin
      if (single_jump) begin
        state_next.trk8 = 3'(state_reg.trk8 + 3'h1);
        if (state_reg.trk8 == `SCSM_TRK8_LAST) begin
          state_next.toggle = !state_reg.toggle;
        end
      end else if (trav_hit) begin
        state_next.trk_cnt = 16'h0000;
        state_next.comp    = 1'b0;
        state_next.toggle  = !state_reg.toggle;
      end else begin
        state_next.trk_cnt = 16'(state_reg.trk_cnt + 16'h0001);
      end
    end

    // The shorter value is left-aligned so bit 8 always leads.
    if (readout_load) begin
      state_next.shift = (pwdata_in[15:8] == `SCSM_RD_RFDC) ?
                         {readout_value_in[7:0], 1'b0} :
                         readout_value_in;
      state_next.left  = (pwdata_in[15:8] == `SCSM_RD_RFDC) ?
                         `SCSM_LEN8 : `SCSM_LEN9;
    end else if (rclk_rise && (state_reg.left != 4'h0)) begin
      state_next.shift = {state_reg.shift[7:0], 1'b0};
      state_next.left  = 4'(state_reg.left - 4'h1);
    end

    // Sense source.
    state_next.sense_oe = 1'b1;
    case (last_code)
      `SCSM_A_FOCUS:  state_next.sense = focus_zero_cross_in;
      `SCSM_A_TRACK:  state_next.sense = anti_shock_in;
      `SCSM_A_TMODE:  state_next.sense = track_zero_cross_in;
      `SCSM_A_SELECT: begin
        if ((last_sub == `SCSM_SUB_LEVEL) && agc_cmd) begin
          state_next.sense = auto_gain_done_in;
        end else if ((last_sub == `SCSM_SUB_LEVEL) &&
                     averaging_active_in) begin
          state_next.sense = average_busy_n_in;
        end else if ((last_sub == `SCSM_SUB_READ) &&
                     is_readout(state_reg.last_cmd[15:8])) begin
          state_next.sense = (state_reg.left != 4'h0) &&
                             state_reg.shift[8];
        end else begin
          state_next.sense = sled_stop_indication_in;
        end
      end
      `SCSM_A_AUTO:   state_next.sense = !auto_seq_running_in;
      `SCSM_A_BLIND:  state_next.sense = focus_ok_in;
      `SCSM_A_AUDIO:  state_next.sense = frame_sync_good_in;
      `SCSM_A_TRAV:   state_next.sense = state_reg.comp;
      `SCSM_A_SPIN:   state_next.sense = state_reg.toggle;
      `SCSM_A_CLVM:   state_next.sense = !run_length_ge64_in;
      default:        state_next.sense = 1'b0;
    endcase
    if (!auto_sequence_enable && !drives_always(last_code)) begin
      state_next.sense    = 1'b0;
      state_next.sense_oe = 1'b0;
    end

    state_next.coef_rd = ({1'b0, coef_rd_addr_in} < `SCSM_COEF_N) ?
                         state_reg.coef[coef_rd_addr_in] : 8'h00;

    // Read data is prepared in the setup cycle for a zero-wait access.
    if (psel_in && penable_in && pwrite_in &&
        (paddr_in == `SCSM_OFF_COEF_IDX)) begin
      state_next.coef_sel = pwdata_in[6:0];
    end
    if (apb_setup) begin
      state_next.pslverr = 1'b0;
      state_next.prdata  = 32'h00000000;
      case (paddr_in)
        `SCSM_OFF_CMD:      state_next.prdata = {8'h00, state_reg.last_cmd};
        `SCSM_OFF_STATUS:   state_next.prdata = {26'h0000000, auto_sequence_enable,
          state_reg.toggle, state_reg.comp, coef_busy,
          state_reg.sense_oe, state_reg.sense};
        `SCSM_OFF_COEF_IDX: state_next.prdata = {25'h0000000,
                                                 state_reg.coef_sel};
        `SCSM_OFF_COEF_DATA: state_next.prdata = {24'h000000,
          ({1'b0, state_reg.coef_sel} < `SCSM_COEF_N) ?
          state_reg.coef[state_reg.coef_sel] : 8'h00};
        default:            state_next.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg           <= '0;
      state_reg.regs      <= PRESETS;
      state_reg.init_busy <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pready_out   = 1'b1;
  assign pslverr_out  = psel_in && penable_in && state_reg.pslverr;
  assign prdata_out   = state_reg.prdata;
  assign coef_rd_data_out   = state_reg.coef_rd;
  assign coef_init_busy_out = coef_busy;
  assign status_sense_pin_out    = state_reg.sense;
  assign status_sense_pin_oe_out = state_reg.sense_oe;
  assign auto_sequence_enable_out = auto_sequence_enable;
  assign auto_seq_command_out =
    state_reg.regs[`SCSM_A_AUTO][`SCSM_AS_RANGE];
  assign blind_brake_timer_field_out =
    state_reg.regs[`SCSM_A_BLIND][`SCSM_TR_RANGE];
  assign sled_kick_timer_field_out =
    state_reg.regs[`SCSM_A_KICK][`SCSM_SD_RANGE];
  assign focus_kick_timer_field_out =
    state_reg.regs[`SCSM_A_KICK][`SCSM_KF_RANGE];
  assign jump_count_out =
    state_reg.regs[`SCSM_A_JUMP][`SCSM_JC_RANGE];
  assign traverse_count_out = trav_count;
  assign speed_drive_gain_out =
    state_reg.regs[`SCSM_A_SPIN][`SCSM_MDS_RANGE];
  assign phase_drive_gain_out =
    state_reg.regs[`SCSM_A_SPIN][`SCSM_MDP_RANGE];
  assign digital_velocity_gain_out =
    state_reg.regs[`SCSM_A_SPIN][`SCSM_DCLV_BIT];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_SELECT_FOLLOWS_WRITE : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    cmd_wr |=> (last_code == $past(pwdata_in[23:20])))
    else $error("sense selection did not follow the write");

  AST_FLOAT_WITHOUT_AUTO_SEQUENCE_ENABLE : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (!auto_sequence_enable && !drives_always(last_code)) |=> !status_sense_pin_oe_out)
    else $error("sense driven while it should float");

  AST_BUSY_SHOWN : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (auto_sequence_enable && last_code == `SCSM_A_AUTO) |=>
    (status_sense_pin_out == !$past(auto_seq_running_in)))
    else $error("busy indication wrong");

  AST_FOCUS_SHOWN : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (auto_sequence_enable && last_code == `SCSM_A_BLIND) |=>
    (status_sense_pin_out == $past(focus_ok_in)))
    else $error("focus ok not copied");

  AST_FRAME_SYNC_SHOWN : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (last_code == `SCSM_A_AUDIO) |=> (status_sense_pin_oe_out &&
    status_sense_pin_out == $past(frame_sync_good_in)))
    else $error("frame sync flag not shown");

  AST_COMPARE_SET : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (cmd_wr && code == `SCSM_A_TRAV) |=>
    (state_reg.comp && state_reg.toggle && state_reg.trk_cnt == 16'h0000))
    else $error("traverse load did not set the flags");

  AST_TOGGLE_ON_COUNT : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (trk_rise && !single_jump && trav_hit && !cmd_wr) |=>
    (state_reg.toggle != $past(state_reg.toggle)) && !state_reg.comp)
    else $error("count reached without toggle");

  AST_EIGHT_COUNT_HOLD : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (trk_rise && single_jump && !cmd_wr &&
     state_reg.trk8 != `SCSM_TRK8_LAST) |=> $stable(state_reg.toggle))
    else $error("toggle moved inside an eight-count");

  AST_OVERLENGTH_SHOWN : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (last_code == `SCSM_A_CLVM) |=>
    (status_sense_pin_out == !$past(run_length_ge64_in)))
    else $error("overlength flag wrong");

  AST_GAIN_DONE_SHOWN : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (auto_sequence_enable && last_code == `SCSM_A_SELECT &&
     last_sub == `SCSM_SUB_LEVEL && agc_cmd) |=>
    (status_sense_pin_out == $past(auto_gain_done_in)))
    else $error("auto gain done not shown");

  AST_INIT_ENDS : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    state_reg.init_busy |-> ##[INIT_MIN:INIT_MAX] !state_reg.init_busy)
    else $error("coefficient init did not end");

  AST_DONT_CARE_KEPT : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (cmd_wr && code == `SCSM_A_AUTO) |=>
    (state_reg.regs[`SCSM_A_AUTO][7:0] ==
     $past(state_reg.regs[`SCSM_A_AUTO][7:0])))
    else $error("don't-care bits were stored");

  AST_READOUT_STEP : assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (rclk_rise && state_reg.left != 4'h0 && !readout_load) |=>
    (state_reg.left == 4'($past(state_reg.left) - 4'h1)))
    else $error("readout did not advance one bit");

endmodule : scsm_top

// ==== sim/scsm_servo_model.sv ====
// Servo-side partner model that produces track pulses.
`timescale 1ns/100ps
module scsm_servo_model (
  input  wire logic mclk_in,
  output logic      track_pulse_out
);
  initial track_pulse_out = 1'b0;
  // Two cycles high and one low, so that every rise is sampled.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      track_pulse_out <= 1'b1;
      repeat (2) @(posedge mclk_in);
      track_pulse_out <= 1'b0;
    end
    @(posedge mclk_in);
  endtask : pulses
endmodule : scsm_servo_model

// ==== sim/scsm_top_bench.sv ====
// Self-checking bench of the servo command and status-sense multiplexer.
`timescale 1ns/100ps
module scsm_top_bench;
  logic clk = 0, rst_n = 0, ps = 0, pe = 0, pw = 0;
  logic [7:0] pa = 0;
  logic [31:0] pd = 0, q;
  logic [11:0] st = 0;
  logic [15:0] jc, tc;
  logic [1:0] mds, mdp;
  logic dv, se, oe, rdy, er, bsy, e, tp;
  logic [3:0] tr, sd, kf;
  logic [31:0] rd;
  int bad_count = 0, total_checks = 0;
  logic [3:0] cd [4] = '{4'h4, 4'h5, 4'ha, 4'he};
  int bi [4] = '{10, 0, 1, 2};
  logic inv [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] ci [4] = '{8'h00, 8'h19, 8'h4f, 8'h30};
  logic [7:0] cv [4] = '{8'he0, 8'hf1, 8'h00, 8'h80};
  always #5 clk = ~clk;
  scsm_servo_model u_scsm_servo_model (.mclk_in(clk), .track_pulse_out(tp));
  scsm_top u_scsm_top (.mclk_in(clk), .rst_n_in(rst_n), .psel_in(ps),
    .penable_in(pe), .pwrite_in(pw), .paddr_in(pa), .pwdata_in(pd),
    .prdata_out(rd), .pready_out(rdy), .pslverr_out(er),
    .auto_seq_running_in(st[10]), .focus_ok_in(st[0]),
    .frame_sync_good_in(st[1]), .track_pulse_input_in(tp),
    .run_length_ge64_in(st[2]), .auto_gain_done_in(st[3]),
    .averaging_active_in(st[4]), .average_busy_n_in(st[5]),
    .sled_stop_indication_in(st[6]), .focus_zero_cross_in(st[7]),
    .anti_shock_in(st[8]), .track_zero_cross_in(st[9]),
    .readout_value_in(9'h1a5), .sense_read_clk_in(st[11]),
    .coef_rd_addr_in(7'h00), .coef_rd_data_out(), .coef_init_busy_out(bsy),
    .status_sense_pin_out(se), .status_sense_pin_oe_out(oe),
    .auto_sequence_enable_out(), .auto_seq_command_out(),
    .blind_brake_timer_field_out(tr), .sled_kick_timer_field_out(sd),
    .focus_kick_timer_field_out(kf), .jump_count_out(jc),
    .traverse_count_out(tc), .speed_drive_gain_out(mds),
    .phase_drive_gain_out(mdp), .digital_velocity_gain_out(dv));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      bad_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ps <= 1; pw <= w; pa <= a; pd <= d; pe <= 0;
    @(posedge clk);
    pe <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    q = rd;
    e = er;
    ps <= 0;
    pe <= 0;
  endtask : apb
  task automatic cmd(input logic [23:0] c);
    apb(1'b1, 8'h00, {8'h00, c});
  endtask : cmd
  task automatic w3();
    repeat (3) @(posedge clk);
    #1;
  endtask : w3
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  initial begin
    #200us;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    #1;
    chk({jc, tc}, 32'h01000100);
    chk({mdp, mds, oe}, 5'b01100);
    $display("test presets done");
    cmd(24'h7abcd0);
    cmd(24'hc540ff);
    w3();
    chk({jc, mdp, mds, dv}, {16'habcd, 5'b01011});
    cmd(24'h6a5000);
    cmd(24'h5c00ff);
    w3();
    chk({tr, sd, kf}, 12'hca5);
    cmd(24'hb0003f);
    w3();
    chk({tc, oe, se}, {16'h0003, 2'b11});
    u_scsm_servo_model.pulses(3);
    w3();
    chk(se, 0);
    cmd(24'hc54000);
    w3();
    chk(se, 0);
    u_scsm_servo_model.pulses(3);
    w3();
    chk(se, 1);
    cmd(24'h500000);
    w3();
    chk(oe, 0);
    $display("test counts done");
    cmd(24'h920000);
    for (int i = 0; i < 4; i++)
      for (int v = 0; v < 2; v++) begin
        cmd({cd[i], 20'h0});
        st[bi[i]] <= v[0];
        w3();
        chk({oe, se}, {1'b1, v[0] ^ inv[i]});
      end
    $display("test sense done");
    cmd(24'h380100);
    st[3] <= 1'b1;
    w3();
    chk(se, 1);
    cmd(24'h380000);
    st[6] <= 1'b1;
    w3();
    chk(se, 1);
    cmd(24'h391f00);
    w3();
    chk(se, 1);
    st[11] <= 1'b1;
    w3();
    st[11] <= 1'b0;
    w3();
    chk(se, 0);
    cmd(24'h440000);
    cmd(24'hb00030);
    cmd(24'hc00000);
    u_scsm_servo_model.pulses(7);
    w3();
    chk(se, 1);
    u_scsm_servo_model.pulses(1);
    w3();
    chk(se, 0);
    $display("test jump done");
    while (bsy !== 1'b0) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h08, {24'h0, ci[i]});
      apb(1'b0, 8'h0c, 32'h0);
      chk(q, {24'h0, cv[i]});
    end
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h00000001);
    chk(q, 32'h00000000);
    $display("test coef done");
    stop_test();
  end
endmodule : scsm_top_bench
